// ---- pkg/pca_pkg.sv ----
// Package for the packet core arithmetic unit: opcodes, widths, limits and timing.
// Assumes a single core clock; used by the arithmetic top and its remainder engine.
package pca_pkg;
  typedef enum logic [2:0] {
    PCA_OP_ADD = 3'h0,
    PCA_OP_SUB = 3'h1,
    PCA_OP_MOD = 3'h2
  } pca_op_t;
  localparam int PCA_WORD_W = 32;
  localparam int PCA_HALF_W = 16;
  localparam int PCA_OFS_W = 5;
  localparam int PCA_SIZE_W = 6;
  localparam int PCA_IMM_W = 16;
  localparam int PCA_REG_W = 4;
  localparam int PCA_SEL_W = 2;
  localparam logic [5:0] PCA_SIZE_MAX_FULL = 6'h20;
  localparam logic [5:0] PCA_SIZE_MAX_HALF = 6'h10;
  localparam logic [5:0] PCA_DIV_MAX_ARITH = 6'h12;
  localparam logic [5:0] PCA_DIV_MAX_LB = 6'h0D;
  localparam logic [31:0] PCA_IMM_MAX_ARITH = 32'h0004_0000;
  localparam logic [31:0] PCA_IMM_MAX_LB = 32'h0000_2000;
  localparam logic [3:0] PCA_FLAGS_RST = 4'h0;
  localparam logic [31:0] PCA_WORD_RST = 32'h0000_0000;
  localparam int PCA_ARITH_STEPS = 32;
  localparam int PCA_LB_STEPS = 8;
endpackage : pca_pkg

// ---- sim/pca_arith_sva.sv ----
// Checker for the arithmetic unit, watching only its top ports.
// Assumes one clock domain; attached by the bind at the foot.
`timescale 1ns/1ps
module pca_arith_sva (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Issue side
  input wire logic i_valid,
  input wire pca_pkg::pca_op_t i_op,
  input wire logic i_flag_update,
  input wire logic o_accept,
  input wire logic o_reject,
  // Result side
  input wire logic o_wb_valid,
  input wire logic o_wb_async,
  input wire logic o_sync_pending,
  input wire logic o_rem_busy,
  input wire logic o_flag_zero,
  input wire logic o_flag_neg,
  input wire logic o_flag_carry,
  input wire logic o_flag_ovf
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence rem_take;
    o_accept && i_op == pca_pkg::PCA_OP_MOD;
  endsequence
  sequence rem_done;
    o_wb_valid && o_wb_async;
  endsequence
  a_sync_wb_next: assert property (
    o_accept && i_op != pca_pkg::PCA_OP_MOD |=> o_wb_valid && o_sync_pending && !o_wb_async)
    else $error("Add or sub write-back missing.");
  a_sync_pend_wb: assert property (
    o_sync_pending |-> o_wb_valid && !o_wb_async)
    else $error("Pending pulse without write-back.");
  a_rem_busy_set: assert property (
    rem_take |=> o_rem_busy [*8])
    else $error("Remainder pending mark dropped early.");
  a_rem_done_bound: assert property (
    rem_take |-> ##[10:34] rem_done)
    else $error("Remainder write-back late.");
  a_async_release: assert property (
    rem_done |-> !o_rem_busy && $past(o_rem_busy))
    else $error("Pending mark not released at write-back.");
  a_busy_refuse: assert property (
    o_rem_busy && i_valid && i_op == pca_pkg::PCA_OP_MOD |-> o_reject)
    else $error("Second remainder taken while busy.");
  a_reject_excl: assert property (
    o_reject && !o_rem_busy |=> !o_wb_valid && !o_rem_busy)
    else $error("Refused request changed the unit.");
  a_flags_hold: assert property (
    !(o_accept && i_flag_update && i_op != pca_pkg::PCA_OP_MOD)
    |=> $stable({o_flag_zero, o_flag_neg, o_flag_carry, o_flag_ovf}))
    else $error("Flags changed without update request.");
endmodule : pca_arith_sva
bind pca_arith_unit pca_arith_sva u_pca_arith_sva (.*);

// ---- sim/pca_dep_model.sv ----
// Dependency checker model standing in for the issue pipeline.
// Assumes the unit's pending marks are looked at in the cycle of a read.
`timescale 1ns/1ps
module pca_dep_model (
  // Pending marks from the unit
  input wire logic i_sync_pending,
  input wire logic [3:0] i_wb_reg,
  input wire logic i_rem_busy,
  input wire logic [3:0] i_rem_reg,
  // Read of the next instruction
  input wire logic [3:0] i_rd_reg,
  output logic o_stall
);
  // stall on pending.
  // Only the write-back releases a remainder mark, so a slow engine keeps the reader waiting.
  assign o_stall = (i_sync_pending && i_wb_reg == i_rd_reg) || (i_rem_busy && i_rem_reg == i_rd_reg);
endmodule : pca_dep_model

// ---- sim/testbench.sv ----
// Self-checking bench for the arithmetic unit with a dependency model.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
module testbench;
  localparam pca_pkg::pca_op_t op_add = pca_pkg::PCA_OP_ADD;
  localparam pca_pkg::pca_op_t op_sub = pca_pkg::PCA_OP_SUB;
  localparam pca_pkg::pca_op_t op_mod = pca_pkg::PCA_OP_MOD;
  logic i_clk = 1'h0, i_rst_n = 1'h0, i_valid = 1'h0, i_use_imm = 1'h0, i_flag_update = 1'h0;
  logic i_sign_extend_option = 1'h0, i_half_width_option = 1'h0, i_zero_dest_first = 1'h0;
  logic i_balancer_remainder_option = 1'h0;
  pca_pkg::pca_op_t i_op = pca_pkg::PCA_OP_ADD;
  logic [31:0] i_first_source_word = '0, i_second_source_word = '0, i_dest_word = 32'hABCD_1234;
  logic [4:0] i_first_offset = '0, i_second_offset = '0;
  logic [5:0] i_first_size = 6'h01, i_second_size = 6'h01;
  logic [15:0] i_imm = '0;
  logic [3:0] i_dest_reg = 4'h5;
  logic [1:0] i_dest_word_select_suffix = '0;
  logic o_accept, o_reject, o_wb_valid, o_wb_async, o_sync_pending, o_rem_busy;
  logic o_flag_zero, o_flag_neg, o_flag_carry, o_flag_ovf, stall;
  logic [3:0] o_wb_reg, o_rem_reg, zncv;
  logic [1:0] o_wb_word_select_suffix, o_rem_word_select_suffix;
  logic [31:0] o_wb_data;
  int err_count = 0, samples_checked = 0, cyc = 0;
  assign zncv = {o_flag_zero, o_flag_neg, o_flag_carry, o_flag_ovf};
  always #2.5 i_clk = ~i_clk;
  pca_arith_unit u_pca_arith_unit (.*);
  pca_dep_model u_pca_dep_model (.i_sync_pending(o_sync_pending), .i_wb_reg(o_wb_reg),
    .i_rem_busy(o_rem_busy), .i_rem_reg(o_rem_reg), .i_rd_reg(i_dest_reg), .o_stall(stall));
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Fields pack as {offset, size}; options as {imm, flag, sx, half, zero, balancer}.
  task automatic ld(input pca_pkg::pca_op_t op, input logic [31:0] a, b, input logic [10:0] f, g,
                    input logic [15:0] m, input logic [5:0] o);
    i_op <= op;
    i_first_source_word <= a;
    i_second_source_word <= b;
    {i_first_offset, i_first_size} <= f;
    {i_second_offset, i_second_size} <= g;
    i_imm <= m;
    {i_use_imm, i_flag_update, i_sign_extend_option, i_half_width_option, i_zero_dest_first,
     i_balancer_remainder_option} <= o;
  endtask : ld
  task automatic sy(input logic [31:0] e, input logic [3:0] z);
    i_valid <= 1'h1;
    #1 chk(o_accept, 1'h1);
    @(posedge i_clk);
    i_valid <= 1'h0;
    #1 chk({o_wb_valid, o_sync_pending, o_wb_async, stall}, 4'hD);
    chk({o_wb_reg, o_wb_word_select_suffix}, {i_dest_reg, i_dest_word_select_suffix});
    chk(o_wb_data, e);
    chk(zncv, z);
    @(posedge i_clk);
    i_dest_word_select_suffix <= i_dest_word_select_suffix + 2'h1;
  endtask : sy
  task automatic rm(input logic [31:0] e, input int k);
    int n = 1;
    i_valid <= 1'h1;
    #1 chk(o_accept, 1'h1);
    @(posedge i_clk);
    #1 chk({o_rem_busy, o_reject, stall}, 3'h7);
    chk({o_rem_reg, o_rem_word_select_suffix}, {i_dest_reg, i_dest_word_select_suffix});
    @(posedge i_clk);
    i_valid <= 1'h0;
    do begin
      @(posedge i_clk);
      n++;
      #1;
    end while ((o_wb_valid & o_wb_async) !== 1'h1 && n < 40);
    chk(n, k);
    chk(o_wb_data, e);
    chk({o_wb_reg, o_wb_word_select_suffix}, {i_dest_reg, i_dest_word_select_suffix});
    @(posedge i_clk);
    #1 chk(o_rem_busy, 1'h0);
    @(posedge i_clk);
  endtask : rm
  task automatic rj;
    i_valid <= 1'h1;
    #1 chk(o_reject, 1'h1);
    @(posedge i_clk);
    i_valid <= 1'h0;
    #1 chk(o_wb_valid | o_rem_busy, 1'h0);
    @(posedge i_clk);
  endtask : rj
  // The ceiling is about fifteen times the expected run of 136 cycles, so a hung remainder cannot stall the bench.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      print_verdict;
    end
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'h1;
    @(posedge i_clk);
    #1 chk({o_wb_valid, o_rem_busy, o_sync_pending, zncv}, pca_pkg::PCA_FLAGS_RST);
    @(posedge i_clk);
    ld(op_add, 32'hFFFF_FFFF, '0, 11'h020, '0, 16'h0001, 6'h30);
    sy('0, 4'hA);
    ld(op_sub, 32'h0000_0005, '0, 11'h008, '0, 16'h0007, 6'h20);
    sy(32'hFFFF_FFFE, 4'hA);
    ld(op_sub, 32'h0000_0005, '0, 11'h008, '0, 16'h0007, 6'h30);
    sy(32'hFFFF_FFFE, 4'h6);
    ld(op_add, 32'h7FFF_FFFF, '0, 11'h020, '0, 16'h0001, 6'h30);
    sy(32'h8000_0000, 4'h5);
    ld(op_add, 32'h1234_5678, 32'h0000_00F0, 11'h110, 11'h108, '0, '0);
    sy(32'h0000_4576, 4'h5);
    ld(op_sub, 32'h0000_0003, '0, 11'h010, '0, 16'h0005, 6'h34);
    sy(32'hABCD_FFFE, 4'h6);
    ld(op_sub, 32'h0000_0003, '0, 11'h010, '0, 16'h0005, 6'h36);
    sy(32'h0000_FFFE, 4'h6);
    ld(op_sub, 32'h0000_0003, '0, 11'h010, '0, 16'h0005, 6'h3C);
    sy(32'hFFFF_FFFE, 4'h6);
    ld(op_add, 32'hFFFF_0000, '0, 11'h410, '0, 16'h0001, 6'h34);
    sy(32'hABCD_0000, 4'hA);
    ld(op_sub, 32'h8000_0000, '0, 11'h020, '0, 16'h0001, 6'h30);
    sy(32'h7FFF_FFFF, 4'h1);
    $display("test add and sub done");
    ld(op_mod, 32'h0000_03E8, 32'h0000_0700, 11'h010, 11'h204, '0, '0);
    rm(32'h0000_0006, pca_pkg::PCA_ARITH_STEPS + 1);
    ld(op_mod, 32'h0001_2345, '0, 11'h020, '0, 16'h2000, 6'h21);
    rm(32'h0000_0345, pca_pkg::PCA_LB_STEPS + 1);
    ld(op_mod, 32'h0000_0123, '0, 11'h010, 11'h004, '0, '0);
    rm(32'h0000_0123, pca_pkg::PCA_ARITH_STEPS + 1);
    $display("test remainder done");
    ld(op_add, 32'h0000_0001, '0, 11'h000, '0, 16'h0001, 6'h20);
    rj;
    ld(op_mod, 32'h0000_0001, '0, 11'h510, '0, 16'h0003, 6'h20);
    rj;
    ld(op_add, 32'h0000_0001, '0, 11'h011, '0, 16'h0001, 6'h24);
    rj;
    ld(op_mod, 32'h0000_0001, 32'h0000_0001, 11'h004, 11'h013, '0, '0);
    rj;
    ld(op_mod, 32'h0000_0001, 32'h0000_0001, 11'h004, 11'h00E, '0, 6'h01);
    rj;
    ld(op_mod, 32'h0000_0001, '0, 11'h004, '0, 16'h0000, 6'h21);
    rj;
    ld(op_mod, 32'h0000_0001, '0, 11'h004, '0, 16'h2001, 6'h21);
    rj;
    $display("test refusals done");
    print_verdict;
  end
endmodule : testbench

// ---- verilog/pca_arith_unit.sv ----
// Arithmetic unit of the packet core: add, subtract and remainder on register bit fields.
// Assumes the issue pipeline supplies operand words and stalls while o_rem_busy is high.
//
// Contract
// RULE1 - Flags change on add or subtract only when flag update is requested.
// RULE2 - Add and subtract write 32 bits, or 16 bits with half width option.
// RULE3 - Sign extend option makes operands signed and sign-extends the result.
// RULE4 - Add extracts source fields starting at a bit offset 0 to 31.
// RULE5 - Fields are at most 32 bits, or 16 bits in half width operation.
// RULE6 - Immediate forms use a 16-bit constant as second operand.
// RULE7 - Half width immediate subtract keeps the upper 16 destination bits.
// RULE8 - Add writes first field plus second field or immediate.
// RULE9 - Subtract writes first field minus second field or immediate.
// RULE10 - Remainder writes first field modulo second field or immediate.
// RULE11 - Remainder is arithmetic by default, load-balancing with the balancer option.
// RULE12 - Load-balancing divisor is 1 to 13 bits, immediate 1 to 8K.
// RULE13 - Arithmetic divisor is 1 to 18 bits, immediate 1 to 256K.
// RULE14 - Dividend size runs from 1 to 32 minus its offset.
// RULE15 - Field upper bit is offset plus size minus one, lower is offset.
// RULE16 - Clear destination option zeroes the whole word before the result lands.
// RULE17 - Word select picks one of four words of a 16-byte register.
// RULE18 - Add flags: zero, top bit, carry out, same-sign overflow.
// RULE19 - Subtract flags: borrow as carry, differing-sign overflow.
// RULE20 - Add and subtract write back one cycle after issue.
// RULE21 - Remainder keeps its destination pending until its write-back.
// RULE22 - Remainder completion pulses write-back valid with register and word.
// RULE23 - Half width flags use bit 15 and 16-bit carry and overflow.
`timescale 1ns/1ps
module pca_arith_unit (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Issue
  input wire logic i_valid,
  input wire pca_pkg::pca_op_t i_op,
  input wire logic i_use_imm,
  input wire logic i_flag_update,
  input wire logic i_sign_extend_option,
  input wire logic i_half_width_option,
  input wire logic i_zero_dest_first,
  input wire logic i_balancer_remainder_option,
  // Operands
  input wire logic [31:0] i_first_source_word,
  input wire logic [4:0] i_first_offset,
  input wire logic [5:0] i_first_size,
  input wire logic [31:0] i_second_source_word,
  input wire logic [4:0] i_second_offset,
  input wire logic [5:0] i_second_size,
  input wire logic [15:0] i_imm,
  input wire logic [31:0] i_dest_word,
  input wire logic [3:0] i_dest_reg,
  input wire logic [1:0] i_dest_word_select_suffix,
  // Issue answer
  output logic o_accept,
  output logic o_reject,
  // Result
  output logic o_wb_valid,
  output logic [3:0] o_wb_reg,
  output logic [1:0] o_wb_word_select_suffix,
  output logic [31:0] o_wb_data,
  output logic o_wb_async,
  // Pending marks
  output logic o_sync_pending,
  output logic o_rem_busy,
  output logic [3:0] o_rem_reg,
  output logic [1:0] o_rem_word_select_suffix,
  // Flags
  output logic o_flag_zero,
  output logic o_flag_neg,
  output logic o_flag_carry,
  output logic o_flag_ovf
);
  // RULE15 field mask from size, low bits set
  function automatic logic [31:0] pca_mask(input logic [5:0] size);
    pca_mask = (size >= pca_pkg::PCA_SIZE_MAX_FULL) ? 32'hFFFF_FFFF : ((32'h0000_0001 << size) - 32'h0000_0001);
  endfunction : pca_mask

  // RULE4 extract field at offset, optionally sign-extended
  function automatic logic [31:0] pca_field(input logic [31:0] word, input logic [4:0] ofs,
                                            input logic [5:0] size, input logic sx);
    logic [31:0] raw;
    logic [31:0] m;
    raw = word >> ofs;
    m = pca_mask(size);
    raw = raw & m;
    if (sx && size != 6'h00 && size < pca_pkg::PCA_SIZE_MAX_FULL && raw[size[4:0] - 5'h01]) begin
      raw = raw | ~m;
    end
    pca_field = raw;
  endfunction : pca_field

  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] b_reg;
  logic [32:0] sum;
  logic [31:0] res;
  logic zf;
  logic nf;
  logic cf;
  logic vf;
  logic legal;
  logic half;
  logic sync_op;
  logic rem_start;
  logic rem_done;
  logic [31:0] rem_val;
  logic rem_busy_q;
  logic [31:0] rem_out;

  assign half = i_half_width_option;
  assign sync_op = (i_op == pca_pkg::PCA_OP_ADD) || (i_op == pca_pkg::PCA_OP_SUB);

  always_comb begin
    a = pca_field(i_first_source_word, i_first_offset, i_first_size, i_sign_extend_option && sync_op);
    b_reg = pca_field(i_second_source_word, i_second_offset, i_second_size, i_sign_extend_option && sync_op);
    // RULE6 immediate replaces second field
    b = i_use_imm ? {16'h0000, i_imm} : b_reg;
    if (i_use_imm && i_sign_extend_option && sync_op && i_imm[15]) begin
      b = {16'hFFFF, i_imm};
    end
  end

  // RULE5 RULE12 RULE13 RULE14 field size checks
  always_comb begin
    legal = 1'b1;
    if (i_first_size == 6'h00 || ({1'b0, i_first_size} + {2'b00, i_first_offset}) > 7'h20) begin
      legal = 1'b0;
    end
    if (sync_op && half && i_first_size > pca_pkg::PCA_SIZE_MAX_HALF) begin
      legal = 1'b0;
    end
    if (!i_use_imm && (i_second_size == 6'h00 || ({1'b0, i_second_size} + {2'b00, i_second_offset}) > 7'h20)) begin
      legal = 1'b0;
    end
    if (sync_op && half && !i_use_imm && i_second_size > pca_pkg::PCA_SIZE_MAX_HALF) begin
      legal = 1'b0;
    end
    if (i_op == pca_pkg::PCA_OP_MOD) begin
      if (i_use_imm) begin
        if (i_imm == 16'h0000) begin
          legal = 1'b0;
        end
        if (i_balancer_remainder_option && {16'h0000, i_imm} > pca_pkg::PCA_IMM_MAX_LB) begin
          legal = 1'b0;
        end
      end else if (i_second_size > (i_balancer_remainder_option ? pca_pkg::PCA_DIV_MAX_LB
                                                                : pca_pkg::PCA_DIV_MAX_ARITH)) begin
        legal = 1'b0;
      end
    end
    if (i_op != pca_pkg::PCA_OP_ADD && i_op != pca_pkg::PCA_OP_SUB && i_op != pca_pkg::PCA_OP_MOD) begin
      legal = 1'b0;
    end
  end

  // RULE8 RULE9 sum or difference with flags
  always_comb begin
    if (i_op == pca_pkg::PCA_OP_SUB) begin
      sum = {1'b0, a} - {1'b0, b};
    end else begin
      sum = {1'b0, a} + {1'b0, b};
    end
    res = sum[31:0];
    if (half) begin
      // RULE23 sixteen-bit flag view
      zf = (res[15:0] == 16'h0000);
      nf = res[15];
      if (i_op == pca_pkg::PCA_OP_SUB) begin
        cf = (a[15:0] < b[15:0]);
        vf = (a[15] != b[15]) && (res[15] != a[15]);
      end else begin
        cf = ({1'b0, a[15:0]} + {1'b0, b[15:0]}) > 17'h0_FFFF;
        vf = (a[15] == b[15]) && (res[15] != a[15]);
      end
    end else begin
      // RULE18 RULE19 full width flags
      zf = (res == 32'h0000_0000);
      nf = res[31];
      if (i_op == pca_pkg::PCA_OP_SUB) begin
        cf = (a < b);
        vf = (a[31] != b[31]) && (res[31] != a[31]);
      end else begin
        cf = sum[32];
        vf = (a[31] == b[31]) && (res[31] != a[31]);
      end
    end
  end

  // RULE21 a remainder is taken only when the engine is idle
  assign rem_start = i_valid && legal && (i_op == pca_pkg::PCA_OP_MOD) && !rem_busy_q;
  // RULE22 keep remainder write-back
  // An add or subtract waits out the cycle in which a remainder retires, so that pulse is never lost.
  assign o_accept = i_valid && legal && (sync_op ? !rem_done : !rem_busy_q);
  assign o_reject = i_valid && !o_accept;

  // RULE11 RULE12 RULE13 balancer variant runs the fast engine mode
  pca_rem_engine u_rem (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(rem_start),
    .i_fast(i_balancer_remainder_option),
    .i_dividend(a),
    .i_divisor(i_use_imm ? {2'b00, i_imm} : b_reg[17:0]),
    .o_busy(),
    .o_done(rem_done),
    .o_rem(rem_val)
  );

  // RULE21 pending mark held until write-back
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rem_busy_q <= 1'b0;
      o_rem_reg <= 4'h0;
      o_rem_word_select_suffix <= 2'h0;
    end else begin
      if (rem_start) begin
        rem_busy_q <= 1'b1;
        o_rem_reg <= i_dest_reg;
        o_rem_word_select_suffix <= i_dest_word_select_suffix;
      end else if (rem_done) begin
        rem_busy_q <= 1'b0;
      end
    end
  end
  assign o_rem_busy = rem_busy_q;

  // RULE10 RULE16 remainder fills word
  // The remainder always writes all 32 bits, so clearing the destination first leaves nothing to zero.
  assign rem_out = rem_val;

  // RULE20 RULE22 write-back one cycle after add or subtract, or on remainder done
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_valid <= 1'b0;
      o_wb_reg <= 4'h0;
      o_wb_word_select_suffix <= 2'h0;
      o_wb_data <= pca_pkg::PCA_WORD_RST;
      o_wb_async <= 1'b0;
    end else begin
      o_wb_valid <= 1'b0;
      o_wb_async <= 1'b0;
      if (o_accept && sync_op) begin
        o_wb_valid <= 1'b1;
        o_wb_reg <= i_dest_reg;
        // RULE17 destination word select
        o_wb_word_select_suffix <= i_dest_word_select_suffix;
        if (half) begin
          // RULE2 RULE7 RULE16 low half written, upper kept or cleared
          o_wb_data <= {i_zero_dest_first ? 16'h0000 : i_dest_word[31:16], res[15:0]};
          // RULE3 sign-extended half result
          if (i_sign_extend_option) begin
            o_wb_data <= {{16{res[15]}}, res[15:0]};
          end
        end else begin
          o_wb_data <= res;
        end
      end else if (rem_done) begin
        o_wb_valid <= 1'b1;
        o_wb_async <= 1'b1;
        o_wb_reg <= o_rem_reg;
        o_wb_word_select_suffix <= o_rem_word_select_suffix;
        o_wb_data <= rem_out;
      end
    end
  end

  // RULE20 one-cycle pending slot
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sync_pending <= 1'b0;
    end else begin
      o_sync_pending <= o_accept && sync_op;
    end
  end

  // RULE1 flags move only with flag update
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {o_flag_zero, o_flag_neg, o_flag_carry, o_flag_ovf} <= pca_pkg::PCA_FLAGS_RST;
    end else if (o_accept && sync_op && i_flag_update) begin
      {o_flag_zero, o_flag_neg, o_flag_carry, o_flag_ovf} <= {zf, nf, cf, vf};
    end
  end
endmodule : pca_arith_unit

// ---- verilog/pca_rem_engine.sv ----
// Iterative remainder engine: restoring division, one or four dividend bits per clock.
// Assumes the caller holds off a new start while busy is high.
`timescale 1ns/1ps
module pca_rem_engine (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Request
  input wire logic i_start,
  input wire logic i_fast,
  input wire logic [31:0] i_dividend,
  input wire logic [17:0] i_divisor,
  // Answer
  output logic o_busy,
  output logic o_done,
  output logic [31:0] o_rem
);
  logic [31:0] quo;
  logic [17:0] div;
  logic [18:0] part;
  logic [5:0] left;
  logic fast;
  logic [18:0] next_part;
  logic [31:0] next_quo;

  // The fast mode retires four bits per clock, trading depth for fewer cycles.
  always_comb begin
    next_part = part;
    next_quo = quo;
    for (int k = 0; k < 4; k++) begin
      if (k == 0 || fast) begin
        next_part = {next_part[17:0], next_quo[31]};
        // The dividend rotates rather than shifts, so a zero divisor can hand it back whole.
        next_quo = {next_quo[30:0], next_quo[31]};
        if (next_part >= {1'b0, div}) begin
          next_part = next_part - {1'b0, div};
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      quo <= pca_pkg::PCA_WORD_RST;
      div <= 18'h0_0000;
      part <= 19'h0_0000;
      left <= 6'h00;
      fast <= 1'b0;
      o_done <= 1'b0;
      o_rem <= pca_pkg::PCA_WORD_RST;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        quo <= i_dividend;
        div <= i_divisor;
        part <= 19'h0_0000;
        fast <= i_fast;
        left <= i_fast ? 6'(pca_pkg::PCA_LB_STEPS) : 6'(pca_pkg::PCA_ARITH_STEPS);
      end else if (left != 6'h00) begin
        part <= next_part;
        quo <= next_quo;
        left <= left - 6'h01;
        if (left == 6'h01) begin
          o_done <= 1'b1;
          o_rem <= (div == 18'h0_0000) ? next_quo : {13'h0000, next_part};
        end
      end
    end
  end

  assign o_busy = (left != 6'h00);
endmodule : pca_rem_engine
